/* umb_pkg.sv */
// umb_pkg: constants and carrier types of the power-supply monitoring register map
package umb_pkg;

   // ==========================================================================
   // function codes and exception codes
   // ==========================================================================
   localparam logic [7:0] FUNC_READ_HOLDING  = 8'h03; // read holding registers
   localparam logic [7:0] FUNC_WRITE_SINGLE  = 8'h06; // write single register
   localparam logic [7:0] EXC_ILLEGAL_FUNC   = 8'h01; // function not supported
   localparam logic [7:0] EXC_ILLEGAL_ADDR   = 8'h02; // address not mapped or not writable
   localparam logic [7:0] EXC_ILLEGAL_VALUE  = 8'h03; // bad quantity or command value
   localparam logic [15:0] MAX_READ_COUNT    = 16'h007d; // largest quantity per read

   // ==========================================================================
   // register addresses (register numbers, one word each)
   // ==========================================================================
   localparam logic [15:0] ADDR_PHASE1_INPUT_VOLTAGE       = 16'h0064;
   localparam logic [15:0] ADDR_PHASE2_INPUT_VOLTAGE       = 16'h0065;
   localparam logic [15:0] ADDR_PHASE3_INPUT_VOLTAGE       = 16'h0066;
   localparam logic [15:0] ADDR_PHASE1_INPUT_CURRENT       = 16'h0067;
   localparam logic [15:0] ADDR_PHASE2_INPUT_CURRENT       = 16'h0068;
   localparam logic [15:0] ADDR_PHASE3_INPUT_CURRENT       = 16'h0069;
   localparam logic [15:0] ADDR_INPUT_FREQUENCY_TENTHS     = 16'h006a;
   localparam logic [15:0] ADDR_PHASE1_OUTPUT_VOLTAGE      = 16'h006b;
   localparam logic [15:0] ADDR_PHASE2_OUTPUT_VOLTAGE      = 16'h006c;
   localparam logic [15:0] ADDR_PHASE3_OUTPUT_VOLTAGE      = 16'h006d;
   localparam logic [15:0] ADDR_PHASE1_OUTPUT_CURRENT      = 16'h006e;
   localparam logic [15:0] ADDR_PHASE2_OUTPUT_CURRENT      = 16'h006f;
   localparam logic [15:0] ADDR_PHASE3_OUTPUT_CURRENT      = 16'h0070;
   localparam logic [15:0] ADDR_OUTPUT_FREQUENCY_TENTHS    = 16'h0071;
   localparam logic [15:0] ADDR_PHASE1_LOAD_PERCENT        = 16'h0072;
   localparam logic [15:0] ADDR_PHASE2_LOAD_PERCENT        = 16'h0073;
   localparam logic [15:0] ADDR_PHASE3_LOAD_PERCENT        = 16'h0074;
   localparam logic [15:0] ADDR_PHASE1_BYPASS_VOLTAGE      = 16'h0075;
   localparam logic [15:0] ADDR_PHASE2_BYPASS_VOLTAGE      = 16'h0076;
   localparam logic [15:0] ADDR_PHASE3_BYPASS_VOLTAGE      = 16'h0077;
   localparam logic [15:0] ADDR_BATTERY_POS_STRING_VOLTAGE = 16'h0078;
   localparam logic [15:0] ADDR_BATTERY_NEG_STRING_VOLTAGE = 16'h0079;
   localparam logic [15:0] ADDR_BATTERY_POS_STRING_CURRENT = 16'h007a;
   localparam logic [15:0] ADDR_BATTERY_NEG_STRING_CURRENT = 16'h007b;
   localparam logic [15:0] ADDR_BATTERY_AMBIENT_TEMP       = 16'h007c;
   localparam logic [15:0] ADDR_DC_BUS_POS_VOLTAGE         = 16'h007d;
   localparam logic [15:0] ADDR_DC_BUS_NEG_VOLTAGE         = 16'h007e;
   localparam logic [15:0] ADDR_CONDITION_ALARM_WORD       = 16'h007f;
   localparam logic [15:0] ADDR_BEEPER_CONTROL             = 16'h00c9;
   localparam logic [15:0] ADDR_BATTERY_TEST_TRIGGER       = 16'h00ca;

   // ==========================================================================
   // measurement block size, command values, reset values
   // ==========================================================================
   localparam int          MEAS_WORDS       = 27;       // words 100..126
   localparam logic [15:0] CMD_OFF          = 16'h0000; // command value zero
   localparam logic [15:0] CMD_ON           = 16'h0001; // command value one
   localparam logic [15:0] BEEPER_RESET     = 16'h0000; // beeper off after reset
   localparam logic [15:0] TEST_RESET       = 16'h0000; // no test requested after reset

   // address block codes
   localparam logic [1:0] BLK_NONE    = 2'h0; // unmapped
   localparam logic [1:0] BLK_MONITOR = 2'h1; // read-only 100..127
   localparam logic [1:0] BLK_COMMAND = 2'h2; // read/write 201..202

   // ==========================================================================
   // carrier types
   // ==========================================================================
   // condition flags, most significant first so that {1'b0, flags} is the word
   typedef struct packed {
      logic general_alarm;          // bit 14
      logic dc_bus_out_of_limits;   // bit 13
      logic emergency_switch_input; // bit 12
      logic battery_failure;        // bit 11
      logic green_mode;             // bit 10
      logic maint_bypass_closed;    // bit 9
      logic bypass_unsynchronised;  // bit 8
      logic ambient_temp_high;      // bit 7
      logic rectifier_temp_high;    // bit 6
      logic inverter_temp_high;     // bit 5
      logic output_overload;        // bit 4
      logic output_out_of_limits;   // bit 3
      logic battery_mode;           // bit 2
      logic bypass_mode;            // bit 1
      logic online_mode;            // bit 0
   } umb_cond_t;

   // one decoded request from the frame layer
   typedef struct packed {
      logic [7:0]  func; // function code
      logic [15:0] addr; // starting register address
      logic [15:0] data; // quantity for reads, value for writes
   } umb_req_t;

   // one answer word or exception
   typedef struct packed {
      logic        exception; // answer is an exception
      logic [7:0]  code;      // exception code, zero otherwise
      logic [15:0] word;      // register word or echoed write value
      logic        last;      // final word of this answer
   } umb_resp_t;

endpackage

/* umb_register_map.sv */
// umb_register_map: monitoring and command register bank behind the frame layer
`timescale 1ns/1ns

module umb_register_map #(
   parameter int          MEAS_COUNT = umb_pkg::MEAS_WORDS,     // measurement words
   parameter logic [15:0] MAX_READ   = umb_pkg::MAX_READ_COUNT  // largest read quantity
) (
   input  wire logic                           clk,                // 20 MHz system clock
   input  wire logic                           rst,                // synchronous, active high
   input  wire logic                           req_valid,          // request offered
   input  wire umb_pkg::umb_req_t              req,                // decoded request
   output logic                                req_ready,          // bank can take a request
   input  wire umb_pkg::umb_cond_t             conditions,         // live condition flags
   input  wire logic [MEAS_COUNT-1:0][15:0]    meas_words,         // live measurements 100..126
   output logic                                resp_valid,         // answer word present
   output umb_pkg::umb_resp_t                  resp,               // answer word or exception
   output logic                                beeper_on,          // audible beeper drive
   output logic                                battery_test_start  // one-cycle test request
);

   // ==========================================================================
   // types and declarations
   // ==========================================================================
   // one-hot answer sequencer
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,  // waiting for a request
      ST_READ = 2'b10   // streaming further read words
   } umb_state_t;

   localparam int IDX_W = $clog2(MEAS_COUNT); // measurement index width

   umb_state_t        state;            // sequencer state
   umb_state_t        next_state;       // sequencer next state
   logic [15:0]       cursor;           // address of the next word to stream
   logic [15:0]       remaining;        // words still to stream
   logic [15:0]       beeper_reg;       // stored beeper command word
   logic [15:0]       test_reg;         // stored battery test command word

   logic              req_take;         // request accepted this cycle
   logic              is_read;          // function 03 request
   logic              is_write;         // function 06 request
   logic [16:0]       span_end;         // last address of a read, with carry
   logic [1:0]        start_blk;        // block of the starting address
   logic              count_ok;         // read quantity in range
   logic              span_ok;          // whole read span inside one block
   logic              write_addr_ok;    // write targets a command register
   logic              write_value_ok;   // write value is zero or one
   logic [15:0]       word_addr;        // address that the read mux looks at
   logic [15:0]       word_value;       // word found at word_addr
   logic [15:0]       meas_index;       // offset inside the measurement block
   logic [15:0]       status_word;      // packed condition word

   // ==========================================================================
   // address decoding
   // ==========================================================================
   // classifies one address; used for both ends of a read span
   function automatic logic [1:0] block_of(input logic [15:0] a);
      if (a >= umb_pkg::ADDR_PHASE1_INPUT_VOLTAGE && a <= umb_pkg::ADDR_CONDITION_ALARM_WORD) begin
         block_of = umb_pkg::BLK_MONITOR;
      end else if (a >= umb_pkg::ADDR_BEEPER_CONTROL && a <= umb_pkg::ADDR_BATTERY_TEST_TRIGGER) begin
         block_of = umb_pkg::BLK_COMMAND;
      end else begin
         block_of = umb_pkg::BLK_NONE;
      end
   endfunction

   // request classification and legality checks
   always_comb begin
      req_take       = req_valid & req_ready;
      is_read        = (req.func == umb_pkg::FUNC_READ_HOLDING);
      is_write       = (req.func == umb_pkg::FUNC_WRITE_SINGLE);
      // carry bit catches a span that wraps past the top address
      span_end       = {1'b0, req.addr} + {1'b0, req.data} - 17'h00001;
      start_blk      = block_of(req.addr);
      count_ok       = (req.data != 16'h0000) && (req.data <= MAX_READ);
      // a span may not bridge the gap between the two blocks
      span_ok        = (start_blk != umb_pkg::BLK_NONE) && !span_end[16]
                       && (block_of(span_end[15:0]) == start_blk);
      write_addr_ok  = (req.addr == umb_pkg::ADDR_BEEPER_CONTROL)
                       || (req.addr == umb_pkg::ADDR_BATTERY_TEST_TRIGGER);
      write_value_ok = (req.data == umb_pkg::CMD_OFF) || (req.data == umb_pkg::CMD_ON);
   end

   // ==========================================================================
   // read multiplexer
   // ==========================================================================
   // the first word comes straight from the request so that it is ready at once
   always_comb begin
      word_addr = (state == ST_IDLE) ? req.addr : cursor;
      meas_index = word_addr - umb_pkg::ADDR_PHASE1_INPUT_VOLTAGE;
      // bit 15 carries no flag and always reads zero
      status_word = {1'b0, conditions};
      word_value = 16'h0000;
      if (word_addr == umb_pkg::ADDR_CONDITION_ALARM_WORD) begin
         // flags land in bits 0..14 in struct order
         word_value = status_word;
      end else if (word_addr == umb_pkg::ADDR_BEEPER_CONTROL) begin
         word_value = beeper_reg;
      end else if (word_addr == umb_pkg::ADDR_BATTERY_TEST_TRIGGER) begin
         word_value = test_reg;
      end else if (block_of(word_addr) == umb_pkg::BLK_MONITOR) begin
         // input/output block 100..113, frequencies in tenths of hertz
         // load percentages 114..116 and bypass voltages follow in order
         // battery strings 120..123, temperature 124, dc bus 125..126
         // words pass as raw unsigned values, no sign handling
         word_value = meas_words[meas_index[IDX_W-1:0]];
      end else begin
         word_value = 16'h0000;  // unreachable through a legal span
      end
   end

   // ==========================================================================
   // sequencer
   // ==========================================================================
   // multi-word reads hold off new requests until the last word is out
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_take && is_read && count_ok && span_ok && (req.data != 16'h0001)) begin
               next_state = ST_READ;
            end
         end
         ST_READ: begin
            if (remaining == 16'h0001) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ready is registered, low for every streaming cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (next_state == ST_IDLE);
      end
   end

   // ==========================================================================
   // read cursor
   // ==========================================================================
   // cursor steps one word per cycle; no stall is needed downstream
   always_ff @(posedge clk) begin
      if (rst) begin
         cursor    <= 16'h0000;
         remaining <= 16'h0000;
      end else if (state == ST_IDLE) begin
         if (req_take) begin
            cursor    <= req.addr + 16'h0001;
            remaining <= req.data - 16'h0001;
         end
      end else begin
         cursor    <= cursor + 16'h0001;
         remaining <= remaining - 16'h0001;
      end
   end

   // ==========================================================================
   // answer register
   // ==========================================================================
   // priority: function, then quantity, then address, then value
   always_ff @(posedge clk) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp       <= '0;
      end else if (state == ST_READ) begin
         // continuing words of a read
         resp_valid     <= 1'b1;
         resp.exception <= 1'b0;
         resp.code      <= 8'h00;
         resp.word      <= word_value;
         resp.last      <= (remaining == 16'h0001);
      end else if (req_take) begin
         resp_valid <= 1'b1;
         resp.last  <= 1'b1;
         if (!is_read && !is_write) begin
            // anything but 03 or 06 is refused
            resp.exception <= 1'b1;
            resp.code      <= umb_pkg::EXC_ILLEGAL_FUNC;
            resp.word      <= 16'h0000;
         end else if (is_read && !count_ok) begin
            resp.exception <= 1'b1;
            resp.code      <= umb_pkg::EXC_ILLEGAL_VALUE;
            resp.word      <= 16'h0000;
         end else if (is_read && !span_ok) begin
            resp.exception <= 1'b1;
            resp.code      <= umb_pkg::EXC_ILLEGAL_ADDR;
            resp.word      <= 16'h0000;
         end else if (is_read) begin
            // first read word, last only for a single-word read
            resp.exception <= 1'b0;
            resp.code      <= 8'h00;
            resp.word      <= word_value;
            resp.last      <= (req.data == 16'h0001);
         end else if (!write_addr_ok) begin
            // read-only and unmapped addresses both refuse a write
            resp.exception <= 1'b1;
            resp.code      <= umb_pkg::EXC_ILLEGAL_ADDR;
            resp.word      <= 16'h0000;
         end else if (!write_value_ok) begin
            resp.exception <= 1'b1;
            resp.code      <= umb_pkg::EXC_ILLEGAL_VALUE;
            resp.word      <= 16'h0000;
         end else begin
            // accepted write echoes its value
            resp.exception <= 1'b0;
            resp.code      <= 8'h00;
            resp.word      <= req.data;
         end
      end else begin
         // answer is a pulse per word; fields hold their last value
         resp_valid <= 1'b0;
      end
   end

   // ==========================================================================
   // command registers
   // ==========================================================================
   // a legal write of zero or one; anything else leaves the register alone
   always_ff @(posedge clk) begin
      if (rst) begin
         beeper_reg <= umb_pkg::BEEPER_RESET;
      end else if (state == ST_IDLE && req_take && is_write && write_value_ok
                   && req.addr == umb_pkg::ADDR_BEEPER_CONTROL) begin
         beeper_reg <= req.data;
      end
   end

   // beeper drive follows the stored command word
   always_ff @(posedge clk) begin
      if (rst) begin
         beeper_on <= 1'b0;
      end else if (state == ST_IDLE && req_take && is_write && write_value_ok
                   && req.addr == umb_pkg::ADDR_BEEPER_CONTROL) begin
         beeper_on <= (req.data == umb_pkg::CMD_ON);
      end
   end

   // test word reads back the last value accepted
   always_ff @(posedge clk) begin
      if (rst) begin
         test_reg <= umb_pkg::TEST_RESET;
      end else if (state == ST_IDLE && req_take && is_write && write_value_ok
                   && req.addr == umb_pkg::ADDR_BATTERY_TEST_TRIGGER) begin
         test_reg <= req.data;
      end
   end

   // each accepted one starts a test, even if the word already held one;
   // the test sequencer itself decides whether a test is already running
   always_ff @(posedge clk) begin
      if (rst) begin
         battery_test_start <= 1'b0;
      end else begin
         battery_test_start <= (state == ST_IDLE) && req_take && is_write
                               && (req.addr == umb_pkg::ADDR_BATTERY_TEST_TRIGGER)
                               && (req.data == umb_pkg::CMD_ON);
      end
   end

endmodule // umb_register_map

/* umb_register_map_sva.sv */
// umb_register_map_sva: port checker for the register map, bound to its top
`timescale 1ns/1ns
module umb_register_map_sva #(
   parameter int          MEAS_COUNT = umb_pkg::MEAS_WORDS,     // measurement words
   parameter logic [15:0] MAX_READ   = umb_pkg::MAX_READ_COUNT  // largest read quantity
) (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        req_valid,
   input wire umb_pkg::umb_req_t           req,
   input wire logic                        req_ready,
   input wire umb_pkg::umb_cond_t          conditions,
   input wire logic [MEAS_COUNT-1:0][15:0] meas_words,
   input wire logic                        resp_valid,
   input wire umb_pkg::umb_resp_t          resp,
   input wire logic                        beeper_on,
   input wire logic                        battery_test_start
);
   // ==========================================================
   // helpers: one clock domain, so one default clocking
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic take = req_valid && req_ready;                  // request taken this edge
   wire logic rd1  = take && req.func == 8'h03 && req.data == 16'h0001; // single-word read
   wire logic wr   = take && req.func == 8'h06;                // write taken
   // ==========================================================
   // assertions
   // ==========================================================
   a_answer_next: assert property (take |=> resp_valid)
      else $error("no answer in the cycle after a request");
   a_status_word: assert property (rd1 && req.addr == 16'h007f |=> resp.word == {1'b0, $past(conditions)} && resp.last)
      else $error("condition word differs from the flags");
   a_load_word: assert property (rd1 && req.addr == 16'h0072 |=> resp.word == $past(meas_words[14]))
      else $error("load word differs from its input");
   a_bad_func: assert property (take && req.func != 8'h03 && req.func != 8'h06 |=> resp.exception && resp.code == 8'h01)
      else $error("unknown function not refused");
   a_readonly_write: assert property (wr && req.addr == 16'h0072 |=> resp.exception && resp.code == 8'h02)
      else $error("write to a read-only word not refused");
   a_unmapped_read: assert property (rd1 && req.addr == 16'h0080 |=> resp.exception && resp.code == 8'h02)
      else $error("unmapped read not refused");
   a_beeper_follow: assert property (wr && req.addr == 16'h00c9 && req.data < 16'h0002 |=> beeper_on == $past(req.data[0]))
      else $error("beeper does not follow its write");
   a_beeper_hold: assert property (!(wr && req.addr == 16'h00c9) |=> $stable(beeper_on))
      else $error("beeper changed without a write");
   a_test_pulse: assert property (wr && req.addr == 16'h00ca && req.data == 16'h0001 |=> battery_test_start ##1 !battery_test_start)
      else $error("battery test pulse missing or too long");
   // main scenarios reached
   c_stream: cover property (take && req.func == 8'h03 && req.data > 16'h0001);
   c_test: cover property (battery_test_start);
   c_refuse: cover property (resp_valid && resp.exception);
endmodule // umb_register_map_sva

bind umb_register_map umb_register_map_sva #(.MEAS_COUNT(MEAS_COUNT), .MAX_READ(MAX_READ)) chk (
   .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .conditions(conditions),
   .meas_words(meas_words), .resp_valid(resp_valid), .resp(resp), .beeper_on(beeper_on),
   .battery_test_start(battery_test_start));

/* umb_master_model.sv */
// umb_master_model: request side of the external monitoring master
`timescale 1ns/1ns
module umb_master_model (
   input  wire logic         clk,
   input  wire logic         req_ready,
   output logic              req_valid,
   output umb_pkg::umb_req_t req
);
   initial begin
      req_valid = 1'b0;
      req       = '0;
   end
   // offer at a falling edge, hold until a rising edge sees ready, release at the next falling edge
   task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clk);
      req_valid = 1'b1;
      req       = '{func: f, addr: a, data: d};
      // ready is registered, so its falling-edge value is what the next edge samples
      while (req_ready !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      req       = ~req; // released lines do not keep the last value
   endtask
endmodule // umb_master_model

/* tb.sv */
// tb: self-checking bench of the register map
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] RD = umb_pkg::FUNC_READ_HOLDING;
   localparam logic [7:0] WR = umb_pkg::FUNC_WRITE_SINGLE;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               req_valid, req_ready, resp_valid, beeper_on, battery_test_start;
   umb_pkg::umb_req_t  req;
   umb_pkg::umb_resp_t resp;
   umb_pkg::umb_cond_t conditions = '0;
   logic [26:0][15:0]  meas_words = '0;
   int                 errors = 0;
   int                 compares = 0;
   int                 cycles = 0;
   always #25 clk = ~clk;
   umb_master_model master (.clk(clk), .req_ready(req_ready), .req_valid(req_valid), .req(req));
   umb_register_map uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .conditions(conditions), .meas_words(meas_words), .resp_valid(resp_valid), .resp(resp),
      .beeper_on(beeper_on), .battery_test_start(battery_test_start));
   // ==========================================================
   // comparison helpers
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // the answer shown in this cycle, valid included
   task automatic answer(input logic e, input logic [7:0] c, input logic [15:0] w, input logic l);
      check({5'h00, resp_valid, resp}, {6'h01, e, c, w, l}, "answer");
   endtask
   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_status();
      for (int i = 0; i < 16; i++) begin
         conditions = (i < 15) ? 15'h0001 << i : 15'h7001; // walking flag, then a mix
         master.send(RD, 16'h007f, 16'h0001);
         answer(1'b0, 8'h00, {1'b0, conditions}, 1'b1);
      end
      $display("status test done");
   endtask
   task automatic t_stream();
      for (int i = 0; i < 27; i++) meas_words[i] = 16'hf000 + 16'(i); // top bit set: unsigned
      master.send(RD, 16'h0064, 16'd27);
      for (int i = 0; i < 27; i++) begin
         answer(1'b0, 8'h00, 16'hf000 + 16'(i), i == 26);
         check(req_ready, i == 26, "ready while streaming");
         @(negedge clk);
      end
      check(resp_valid, 1'b0, "stream end");
      // single-word read of the first load word, so the load assertion is reached
      master.send(RD, 16'h0072, 16'h0001);
      answer(1'b0, 8'h00, 16'hf00e, 1'b1);
      $display("stream test done");
   endtask
   task automatic t_beeper();
      master.send(RD, 16'h00c9, 16'h0001);
      answer(1'b0, 8'h00, 16'h0000, 1'b1);
      master.send(WR, 16'h00c9, 16'h0001);
      answer(1'b0, 8'h00, 16'h0001, 1'b1);
      check(beeper_on, 1'b1, "beeper on");
      master.send(WR, 16'h00c9, 16'h0002);
      answer(1'b1, 8'h03, 16'h0000, 1'b1);
      master.send(RD, 16'h00c9, 16'h0001);
      answer(1'b0, 8'h00, 16'h0001, 1'b1);
      master.send(WR, 16'h00c9, 16'h0000);
      answer(1'b0, 8'h00, 16'h0000, 1'b1);
      check(beeper_on, 1'b0, "beeper off");
      $display("beeper test done");
   endtask
   task automatic t_battery();
      master.send(WR, 16'h00ca, 16'h0001);
      answer(1'b0, 8'h00, 16'h0001, 1'b1);
      check(battery_test_start, 1'b1, "test pulse");
      @(negedge clk);
      check(battery_test_start, 1'b0, "test pulse end");
      master.send(RD, 16'h00ca, 16'h0001);
      answer(1'b0, 8'h00, 16'h0001, 1'b1);
      $display("battery test done");
   endtask
   // refusals: bad function, read-only write, unmapped, crossing, bad quantities
   task automatic t_refuse();
      logic [7:0]  f[6] = '{8'h10, WR, RD, RD, RD, RD};
      logic [15:0] a[6] = '{16'h0064, 16'h0072, 16'h0080, 16'h007f, 16'h0064, 16'h0064};
      logic [15:0] d[6] = '{16'h0001, 16'h0005, 16'h0001, 16'h0002, 16'h0000, 16'h007e};
      logic [7:0]  c[6] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03};
      for (int i = 0; i < 6; i++) begin
         master.send(f[i], a[i], d[i]);
         answer(1'b1, c[i], 16'h0000, 1'b1);
      end
      $display("refusal test done");
   endtask
   // ==========================================================
   // main sequence and hang guard
   // ==========================================================
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         $display("unexpected at %0t: timeout", $time);
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_status();
      t_stream();
      t_beeper();
      t_battery();
      t_refuse();
      summarize();
   end
endmodule // tb
